// [core/qdl_pkg.sv]
`default_nettype none

package qdl_pkg;

    typedef enum logic [0:0] {
        QDL_VAR_WIDE = 1'b0,
        QDL_VAR_NARROW = 1'b1
    } qdl_variant_t;

    typedef enum logic [1:0] {
        QDL_ST_POR = 2'b01,
        QDL_ST_RUN = 2'b10
    } qdl_state_t;

endpackage

`default_nettype wire

// [core/qdl_regs.svh]
`ifndef QDL_REGS_SVH
`define QDL_REGS_SVH

// Channel count and code widths of the two build variants
`define QDL_NUM_CHAN 4
`define QDL_WIDE_DATA_W 16
`define QDL_NARROW_DATA_W 14

// Serial word length: two address bits on top of the code
`define QDL_ADDR_W 2
`define QDL_WIDE_WORD_W 18
`define QDL_NARROW_WORD_W 16

// Serial output lag in link clock pulses
`define QDL_WIDE_SDO_DLY 19
`define QDL_NARROW_SDO_DLY 17

// Preset codes
`define QDL_WIDE_HALF_CODE 16'h8000
`define QDL_NARROW_HALF_CODE 14'h2000
`define QDL_ZERO_CODE 16'h0000

// Pin synchroniser depth and power-on settle time in reference cycles
`define QDL_SYNC_STAGES 2
`define QDL_POR_CYC 3

// Sync chain bit positions and idle levels
`define QDL_PIN_CS_N 0
`define QDL_PIN_PRESET_N 1
`define QDL_PIN_LOAD_N 2
`define QDL_PIN_LEVEL 3
`define QDL_PIN_IDLE 4'h7

`endif

// [core/qdl_serial_load.sv]
`timescale 1ns/10ps
`default_nettype none

`include "qdl_regs.svh"

module qdl_serial_load #(
    parameter qdl_pkg::qdl_variant_t VARIANT = qdl_pkg::QDL_VAR_WIDE,
    parameter int SDO_DELAY = `QDL_WIDE_SDO_DLY
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_link_clk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic i_async_preset_n,
    input wire logic i_output_load_strobe_n,
    input wire logic i_preset_level,
    output logic o_sdo,
    output logic [((VARIANT == qdl_pkg::QDL_VAR_WIDE) ? `QDL_WIDE_DATA_W
                    : `QDL_NARROW_DATA_W)-1:0] o_ch0_code,
    output logic [((VARIANT == qdl_pkg::QDL_VAR_WIDE) ? `QDL_WIDE_DATA_W
                    : `QDL_NARROW_DATA_W)-1:0] o_ch1_code,
    output logic [((VARIANT == qdl_pkg::QDL_VAR_WIDE) ? `QDL_WIDE_DATA_W
                    : `QDL_NARROW_DATA_W)-1:0] o_ch2_code,
    output logic [((VARIANT == qdl_pkg::QDL_VAR_WIDE) ? `QDL_WIDE_DATA_W
                    : `QDL_NARROW_DATA_W)-1:0] o_ch3_code,
    output logic o_frame_active,
    output logic o_word_taken,
    output logic [`QDL_ADDR_W-1:0] o_word_chan,
    output logic o_ready
);

    import qdl_pkg::*;

    // Variant selects widths, word length, half code and output lag together
    localparam bit WIDE = (VARIANT == QDL_VAR_WIDE);
    localparam int DATA_W = WIDE ? `QDL_WIDE_DATA_W : `QDL_NARROW_DATA_W;
    localparam int WORD_W = WIDE ? `QDL_WIDE_WORD_W : `QDL_NARROW_WORD_W;
    localparam int EXP_SDO = WIDE ? `QDL_WIDE_SDO_DLY : `QDL_NARROW_SDO_DLY;
    localparam int NCH = `QDL_NUM_CHAN;
    localparam int NPIN = 4;
    localparam int POR_W = 2;
    localparam logic [DATA_W-1:0] HALF_CODE = WIDE
        ? DATA_W'(`QDL_WIDE_HALF_CODE) : DATA_W'(`QDL_NARROW_HALF_CODE);
    localparam logic [DATA_W-1:0] ZERO_CODE = DATA_W'(`QDL_ZERO_CODE);
    localparam logic [NPIN-1:0] PIN_IDLE = NPIN'(`QDL_PIN_IDLE);
    localparam logic [POR_W-1:0] POR_LAST = POR_W'(`QDL_POR_CYC - 1);

    // The shifter delays by its length plus one output flop
    generate
        if (SDO_DELAY != EXP_SDO) begin : g_bad_delay
            $error("qdl_serial_load: SDO_DELAY does not match variant");
        end
        if (WORD_W != DATA_W + `QDL_ADDR_W) begin : g_bad_word
            $error("qdl_serial_load: word length mismatch");
        end
        if (`QDL_POR_CYC > (1 << POR_W)) begin : g_bad_por
            $error("qdl_serial_load: power-on count too wide");
        end
    endgenerate

    // Preset code chosen by the sampled level select
    function automatic logic [DATA_W-1:0] preset_code(input logic level);
        preset_code = level ? HALF_CODE : ZERO_CODE;
    endfunction

    // One-hot channel select from the two address bits
    function automatic logic [NCH-1:0] chan_decode(input logic [`QDL_ADDR_W-1:0] addr);
        chan_decode = '0;
        if (addr == 2'h0) begin
            chan_decode[0] = 1'b1;
        end else if (addr == 2'h1) begin
            chan_decode[1] = 1'b1;
        end else if (addr == 2'h2) begin
            chan_decode[2] = 1'b1;
        end else begin
            chan_decode[3] = 1'b1;
        end
    endfunction

    // ---------------- Link domain ----------------

    logic [WORD_W-1:0] link_word;
    logic link_sdo;
    logic link_rst_ff;
    logic nxt_link_rst;

    qdl_serial_shifter #(
        .WORD_W(WORD_W)
    ) u_shifter (
        .i_link_clk(i_link_clk),
        .i_link_arst(link_rst_ff),
        .i_cs_n(i_cs_n),
        .i_sdi(i_sdi),
        .o_word(link_word),
        .o_sdo(link_sdo)
    );

    // Output flop of the shifter is the pin driver itself
    assign o_sdo = link_sdo;

    // Registered reset for the link side, so no glitch reaches its clear
    always_comb begin
        nxt_link_rst = i_srst;
    end

    always_ff @(posedge i_ref_clk) begin
        link_rst_ff <= nxt_link_rst;
    end

    // ---------------- Pin synchronisers ----------------

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] meta_ff;
    logic [NPIN-1:0] sync_ff;
    logic [NPIN-1:0] nxt_meta;
    logic [NPIN-1:0] nxt_sync;

    assign pin_raw[`QDL_PIN_CS_N] = i_cs_n;
    assign pin_raw[`QDL_PIN_PRESET_N] = i_async_preset_n;
    assign pin_raw[`QDL_PIN_LOAD_N] = i_output_load_strobe_n;
    assign pin_raw[`QDL_PIN_LEVEL] = i_preset_level;

    // The asynchronous pins are taken through two flops; the price is
    // about two reference cycles of latency on preset and load.
    generate
        for (genvar p = 0; p < NPIN; p++) begin : g_sync
            always_comb begin
                nxt_meta[p] = i_srst ? PIN_IDLE[p] : pin_raw[p];
                nxt_sync[p] = i_srst ? PIN_IDLE[p] : meta_ff[p];
            end

            always_ff @(posedge i_ref_clk) begin
                meta_ff[p] <= nxt_meta[p];
                sync_ff[p] <= nxt_sync[p];
            end
        end
    endgenerate

    logic cs_n_s;
    logic preset_n_s;
    logic load_n_s;
    logic level_s;

    assign cs_n_s = sync_ff[`QDL_PIN_CS_N];
    assign preset_n_s = sync_ff[`QDL_PIN_PRESET_N];
    assign load_n_s = sync_ff[`QDL_PIN_LOAD_N];
    assign level_s = sync_ff[`QDL_PIN_LEVEL];

    // ---------------- Frame end detection ----------------

    logic cs_prev_ff;
    logic nxt_cs_prev;
    logic cs_rise;

    always_comb begin
        nxt_cs_prev = i_srst ? 1'b1 : cs_n_s;
    end

    always_ff @(posedge i_ref_clk) begin
        cs_prev_ff <= nxt_cs_prev;
    end

    // The link clock is idle while select is high, so the shifter word
    // is static when the synchronised rise is seen and may be read whole.
    assign cs_rise = cs_n_s && !cs_prev_ff;

    logic [`QDL_ADDR_W-1:0] word_addr;
    logic [DATA_W-1:0] word_data;
    logic [NCH-1:0] word_sel;

    assign word_addr = link_word[WORD_W-1 -: `QDL_ADDR_W];
    assign word_data = link_word[DATA_W-1:0];
    assign word_sel = chan_decode(word_addr);

    // ---------------- Power-on sequencing ----------------

    qdl_state_t state_ff;
    qdl_state_t nxt_state;
    logic [POR_W-1:0] por_cnt_ff;
    logic [POR_W-1:0] nxt_por_cnt;
    logic por_apply;

    // Waits until the level select has crossed its synchroniser
    always_comb begin
        nxt_state = state_ff;
        nxt_por_cnt = por_cnt_ff;
        por_apply = 1'b0;
        case (state_ff)
            QDL_ST_POR: begin
                if (por_cnt_ff == POR_LAST) begin
                    por_apply = 1'b1;
                    nxt_state = QDL_ST_RUN;
                end else begin
                    nxt_por_cnt = por_cnt_ff + POR_W'(1);
                end
            end
            QDL_ST_RUN: begin
                nxt_state = QDL_ST_RUN;
            end
            default: begin
                nxt_state = QDL_ST_POR;
                nxt_por_cnt = '0;
            end
        endcase
        if (i_srst) begin
            nxt_state = QDL_ST_POR;
            nxt_por_cnt = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        state_ff <= nxt_state;
        por_cnt_ff <= nxt_por_cnt;
    end

    // ---------------- Data and output registers ----------------

    logic [DATA_W-1:0] data_ff [NCH];
    logic [DATA_W-1:0] out_ff [NCH];
    logic [DATA_W-1:0] nxt_data [NCH];
    logic [DATA_W-1:0] nxt_out [NCH];
    logic running;
    logic force_preset;

    assign running = (state_ff == QDL_ST_RUN);
    // Preset overrides serial writes and the load strobe
    assign force_preset = por_apply || (running && !preset_n_s);

    generate
        for (genvar c = 0; c < NCH; c++) begin : g_chan
            always_comb begin
                nxt_data[c] = data_ff[c];
                nxt_out[c] = out_ff[c];
                if (i_srst) begin
                    nxt_data[c] = ZERO_CODE;
                    nxt_out[c] = ZERO_CODE;
                end else if (force_preset) begin
                    nxt_data[c] = preset_code(level_s);
                    nxt_out[c] = preset_code(level_s);
                end else if (running) begin
                    if (cs_rise && word_sel[c]) begin
                        nxt_data[c] = word_data;
                    end
                    // Transparent latch: a word landing while the strobe
                    // is low reaches the output in the same cycle.
                    if (!load_n_s) begin
                        nxt_out[c] = nxt_data[c];
                    end
                end
            end

            always_ff @(posedge i_ref_clk) begin
                data_ff[c] <= nxt_data[c];
                out_ff[c] <= nxt_out[c];
            end
        end
    endgenerate

    assign o_ch0_code = out_ff[0];
    assign o_ch1_code = out_ff[1];
    assign o_ch2_code = out_ff[2];
    assign o_ch3_code = out_ff[3];

    // ---------------- Status ----------------

    logic frame_ff;
    logic taken_ff;
    logic ready_ff;
    logic [`QDL_ADDR_W-1:0] chan_ff;
    logic nxt_frame;
    logic nxt_taken;
    logic nxt_ready;
    logic [`QDL_ADDR_W-1:0] nxt_chan;

    always_comb begin
        nxt_frame = !cs_n_s;
        nxt_taken = running && cs_rise && preset_n_s;
        nxt_chan = nxt_taken ? word_addr : chan_ff;
        nxt_ready = running;
        if (i_srst) begin
            nxt_frame = 1'b0;
            nxt_taken = 1'b0;
            nxt_chan = '0;
            nxt_ready = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        frame_ff <= nxt_frame;
        taken_ff <= nxt_taken;
        chan_ff <= nxt_chan;
        ready_ff <= nxt_ready;
    end

    assign o_frame_active = frame_ff;
    assign o_word_taken = taken_ff;
    assign o_word_chan = chan_ff;
    assign o_ready = ready_ff;

endmodule

`default_nettype wire

// [core/qdl_serial_shifter.sv]
`timescale 1ns/10ps
`default_nettype none

// Link-side shift register, clocked only by the serial clock
module qdl_serial_shifter #(
    parameter int WORD_W = 18
) (
    input wire logic i_link_clk,
    input wire logic i_link_arst,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    output logic [WORD_W-1:0] o_word,
    output logic o_sdo
);

    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] nxt_shift;
    logic sdo_ff;
    logic nxt_sdo;

    generate
        if (WORD_W < 3) begin : g_bad_width
            $error("qdl_serial_shifter: WORD_W too small");
        end
    endgenerate

    // Data enters straight from the pin, top bit first, moving upward
    always_comb begin
        nxt_shift = shift_ff;
        nxt_sdo = sdo_ff;
        if (!i_cs_n) begin
            nxt_shift = {shift_ff[WORD_W-2:0], i_sdi};
            nxt_sdo = shift_ff[WORD_W-1];
        end
    end

    // Reset is asynchronous here because the link clock may be stopped
    // throughout the core reset; only constants are loaded by it.
    always_ff @(posedge i_link_clk or posedge i_link_arst) begin
        if (i_link_arst) begin
            shift_ff <= '0;
            sdo_ff <= 1'b0;
        end else begin
            shift_ff <= nxt_shift;
            sdo_ff <= nxt_sdo;
        end
    end

    assign o_word = shift_ff;
    assign o_sdo = sdo_ff;

endmodule

`default_nettype wire

// [tb/qdl_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Host side of the link; its clock stands low outside frames
module qdl_host_model (
    output logic o_link_clk,
    output logic o_cs_n,
    output logic o_sdi
);
    initial begin
        o_link_clk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end

    // Data moves on the falling clock so it is stable around each rise
    task automatic send(input logic [31:0] word, input int nbits);
        #13 o_cs_n = 1'b0;
        #37;
        for (int i = nbits - 1; i >= 0; i--) begin
            o_sdi = word[i];
            #62.5 o_link_clk = 1'b1;
            #62.5 o_link_clk = 1'b0;
        end
        #40 o_cs_n = 1'b1;
        // Released line shows the inverse so a stale bit cannot pass
        o_sdi = ~o_sdi;
        #450;
    endtask
endmodule

`default_nettype wire

// [tb/qdl_load_checker.sv]
`timescale 1ns/10ps
`default_nettype none

`include "qdl_regs.svh"

module qdl_load_checker
    import qdl_pkg::*;
#(
    parameter qdl_pkg::qdl_variant_t VARIANT = qdl_pkg::QDL_VAR_WIDE,
    parameter int SDO_DELAY = `QDL_WIDE_SDO_DLY,
    parameter int DW = (VARIANT == QDL_VAR_WIDE) ? `QDL_WIDE_DATA_W : `QDL_NARROW_DATA_W
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_link_clk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    input wire logic i_async_preset_n,
    input wire logic i_output_load_strobe_n,
    input wire logic i_preset_level,
    input wire logic o_sdo,
    input wire logic [DW-1:0] o_ch0_code,
    input wire logic [DW-1:0] o_ch1_code,
    input wire logic [DW-1:0] o_ch2_code,
    input wire logic [DW-1:0] o_ch3_code,
    input wire logic o_frame_active,
    input wire logic o_word_taken,
    input wire logic [`QDL_ADDR_W-1:0] o_word_chan,
    input wire logic o_ready
);
    localparam logic [DW-1:0] HALF = (VARIANT == QDL_VAR_WIDE) ? DW'(`QDL_WIDE_HALF_CODE)
        : DW'(`QDL_NARROW_HALF_CODE);
    logic [4*DW-1:0] codes;
    logic [4:0] lnk_cnt_ff;
    logic [4:0] nxt_lnk_cnt;
    assign codes = {o_ch0_code, o_ch1_code, o_ch2_code, o_ch3_code};

    always_comb begin
        nxt_lnk_cnt = (lnk_cnt_ff < 5'(SDO_DELAY)) ? lnk_cnt_ff + 5'h01 : lnk_cnt_ff;
    end
    // Serial out is judged only once its whole history is from after reset
    always_ff @(posedge i_link_clk or posedge i_srst) begin
        if (i_srst) begin
            lnk_cnt_ff <= 5'h00;
        end else begin
            lnk_cnt_ff <= nxt_lnk_cnt;
        end
    end

    sequence s_held;
        (i_output_load_strobe_n && i_async_preset_n) [*4];
    endsequence
    sequence s_preset(lvl);
        (!i_async_preset_n && i_preset_level == lvl) [*4];
    endsequence
    sequence s_sel_low;
        (!i_cs_n) [*5];
    endsequence

    taken_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_word_taken |=> !o_word_taken) else $error("taken held high");
    taken_ready_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_word_taken |-> o_ready) else $error("word taken before ready");
    code_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        s_held ##0 $past(o_ready) |-> $stable(codes)) else $error("codes moved while held");
    sel_seen_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        s_sel_low ##0 o_ready |-> o_frame_active) else $error("frame not seen");
    commit_taken_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        $fell(o_frame_active) && i_async_preset_n |-> ##[0:4] o_word_taken)
        else $error("frame end without commit");
    preset_half_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        s_preset(1'b1) ##0 $past(o_ready) |-> codes == {4{HALF}}) else $error("no half");
    preset_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        s_preset(1'b0) ##0 $past(o_ready) |-> codes == '0) else $error("no zero");
    sdo_delay_a: assert property (@(posedge i_link_clk) disable iff (i_srst)
        !i_cs_n && lnk_cnt_ff >= 5'(SDO_DELAY) |-> o_sdo == $past(i_sdi, SDO_DELAY))
        else $error("serial out lag wrong");
endmodule

bind qdl_serial_load qdl_load_checker #(.VARIANT(VARIANT), .SDO_DELAY(SDO_DELAY)) u_chk (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_link_clk(i_link_clk), .i_cs_n(i_cs_n),
    .i_sdi(i_sdi), .i_async_preset_n(i_async_preset_n),
    .i_output_load_strobe_n(i_output_load_strobe_n), .i_preset_level(i_preset_level),
    .o_sdo(o_sdo), .o_ch0_code(o_ch0_code), .o_ch1_code(o_ch1_code),
    .o_ch2_code(o_ch2_code), .o_ch3_code(o_ch3_code), .o_frame_active(o_frame_active),
    .o_word_taken(o_word_taken), .o_word_chan(o_word_chan), .o_ready(o_ready));

`default_nettype wire

// [tb/quad_dac_serial_load_logic_test.sv]
`timescale 1ns/10ps
`default_nettype none

`include "qdl_regs.svh"

module quad_dac_serial_load_logic_test;
    import qdl_pkg::*;
    localparam int HALF = `QDL_WIDE_HALF_CODE;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic preset_n = 1'b1;
    logic load_n = 1'b1;
    logic level = 1'b1;
    logic link_clk, cs_n, sdi, sdo, active, taken, ready;
    logic [1:0] chan;
    logic [15:0] code [4];
    int err_count = 0;
    int comparisons = 0;
    int mdata [4];
    int mout [4];
    // Every bit the shifter has taken since reset, oldest first
    int sent_bits [$];

    always #50 clk = ~clk;

    qdl_host_model host (.o_link_clk(link_clk), .o_cs_n(cs_n), .o_sdi(sdi));
    qdl_serial_load #(.VARIANT(QDL_VAR_WIDE), .SDO_DELAY(`QDL_WIDE_SDO_DLY)) dut (
        .i_ref_clk(clk), .i_srst(srst), .i_link_clk(link_clk), .i_cs_n(cs_n), .i_sdi(sdi),
        .i_async_preset_n(preset_n), .i_output_load_strobe_n(load_n), .i_preset_level(level),
        .o_sdo(sdo), .o_ch0_code(code[0]), .o_ch1_code(code[1]), .o_ch2_code(code[2]),
        .o_ch3_code(code[3]), .o_frame_active(active), .o_word_taken(taken),
        .o_word_chan(chan), .o_ready(ready));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_outs();
        for (int c = 0; c < 4; c++) begin
            check("code", code[c], mout[c]);
        end
    endtask

    task automatic wait_for(input bit want_ready, input int lim);
        for (int i = 0; i < lim; i++) begin
            tick(1);
            if ((want_ready ? ready : taken) === 1'b1) begin
                return;
            end
        end
        err_count++;
        $display("BAD wait expected 1 seen 0");
        print_verdict();
    endtask

    task automatic set_regs(input int v, input bit outs_too);
        for (int c = 0; c < 4; c++) begin
            mdata[c] = v;
            if (outs_too) begin
                mout[c] = v;
            end
        end
    endtask

    task automatic do_reset(input logic lvl);
        @(posedge clk) srst <= 1'b1;
        level <= lvl;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        // Cleared shifter and output flop look like nineteen zero bits
        sent_bits.delete();
        repeat (19) sent_bits.push_back(0);
        wait_for(1'b1, 12);
        set_regs(lvl ? HALF : 0, 1'b1);
        check_outs();
    endtask

    // Extra leading bits are random so a design that keeps them shows it
    task automatic write_word(input int ch, input int val, input int extra);
        logic [31:0] w;
        val = val & 32'h0000_ffff;
        w = ($urandom() << 18) | (ch << 16) | val;
        fork
            host.send(w, 18 + extra);
            wait_for(1'b0, 60);
        join
        for (int i = 17 + extra; i >= 0; i--) begin
            sent_bits.push_back(w[i]);
        end
        check("chan", chan, ch);
        check("sdo", sdo, sent_bits[sent_bits.size() - 19]);
        mdata[ch] = val;
        if (load_n === 1'b0) begin
            mout[ch] = val;
        end
        tick(2);
        check_outs();
    endtask

    task automatic pulse_load();
        @(posedge clk) load_n <= 1'b0;
        tick(5);
        mout = mdata;
        check_outs();
        @(posedge clk) load_n <= 1'b1;
        tick(4);
    endtask

    task automatic do_preset(input logic lvl);
        @(posedge clk) level <= lvl;
        preset_n <= 1'b0;
        tick(5);
        set_regs(lvl ? HALF : 0, 1'b1);
        check_outs();
        @(posedge clk) preset_n <= 1'b1;
        tick(4);
    endtask

    initial begin
        void'($urandom(32'he6e7));
        do_reset(1'b1);
        $display("test power-on done");
        for (int c = 0; c < 4; c++) begin
            write_word(c, $urandom(), 0);
        end
        pulse_load();
        $display("test hold and load done");
        write_word(0, 32'h0000_ffff, 14);
        write_word(3, 32'h0000_0000, 1);
        write_word(1, $urandom(), 6);
        pulse_load();
        $display("test extra bits done");
        @(posedge clk) load_n <= 1'b0;
        tick(4);
        write_word(2, $urandom(), 0);
        write_word(2, $urandom(), 0);
        @(posedge clk) load_n <= 1'b1;
        tick(4);
        $display("test transparent done");
        do_preset(1'b0);
        pulse_load();
        do_preset(1'b1);
        pulse_load();
        write_word(3, $urandom(), 0);
        pulse_load();
        $display("test preset done");
        do_reset(1'b0);
        write_word(1, $urandom(), 2);
        pulse_load();
        $display("test second reset done");
        print_verdict();
    end
endmodule

`default_nettype wire
